// ---- rtl/wpcr_defines.svh ----
// Constants of the pulse count relay: timing, register offsets, reset values.
// Included by the package and by every design file; definitions only.
`ifndef WPCR_DEFINES_SVH
`define WPCR_DEFINES_SVH

`define WPCR_CLK_MHZ        250
`define WPCR_CNT_W          30
// Low-pass settle time; rejects contact chatter, passes up to about 100 Hz
`define WPCR_FILT_US        5000
`define WPCR_FAST_PERIOD_US 100
`define WPCR_SLOW_PERIOD_MS 100
`define WPCR_MEAS_MS        1500
`define WPCR_SEND_MS        100
`define WPCR_FLASH_MS       250
`define WPCR_FILT_CYC       (`WPCR_FILT_US * `WPCR_CLK_MHZ)
`define WPCR_FAST_HALF_CYC  (`WPCR_FAST_PERIOD_US * `WPCR_CLK_MHZ / 2)
`define WPCR_SLOW_HALF_CYC  (`WPCR_SLOW_PERIOD_MS * 1000 * `WPCR_CLK_MHZ / 2)
`define WPCR_MEAS_CYC       (`WPCR_MEAS_MS * 1000 * `WPCR_CLK_MHZ)
`define WPCR_SEND_CYC       (`WPCR_SEND_MS * 1000 * `WPCR_CLK_MHZ)
`define WPCR_FLASH_CYC      (`WPCR_FLASH_MS * 1000 * `WPCR_CLK_MHZ)

`define WPCR_CFG_SETTLE     2'h2
`define WPCR_TX_EN_RST      1'b1

`define WPCR_REG_CTRL       8'h00
`define WPCR_REG_STATUS     8'h04
`define WPCR_REG_CNT0       8'h08
`define WPCR_REG_CNT1       8'h0C
`define WPCR_REG_FREQ0      8'h10
`define WPCR_REG_FREQ1      8'h14
`define WPCR_REG_PEND0      8'h18
`define WPCR_REG_PEND1      8'h1C

`endif

// ---- rtl/wpcr_pkg.sv ----
// Types of the pulse count relay: switch sets, link message, state records.
// Assumes wpcr_defines.svh on the include path.
`include "wpcr_defines.svh"

package wpcr_pkg;

  typedef struct packed {
    logic coupling_ac;
    logic impedance_high;
    logic freq_mode;
    logic speed_high;
    logic differential;
  } wpcr_in_dip_t;

  typedef struct packed {
    logic freq_mode;
    logic speed_low;
  } wpcr_out_dip_t;

  typedef struct packed {
    logic [2:0]             addr;
    logic                   chan;
    logic                   freq_mode;
    logic [`WPCR_CNT_W-1:0] value;
  } wpcr_msg_t;

  typedef struct packed {
    logic [8:0]           rsvd;
    logic [2:0]           addr;
    wpcr_out_dip_t [1:0]  out_cfg;
    wpcr_in_dip_t [1:0]   in_cfg;
    logic [1:0]           mismatch;
    logic                 match_seen;
    logic                 link_ok;
    logic                 tx_busy;
    logic                 cfg_done;
  } wpcr_status_t;

  typedef enum logic [0:0] {
    WPCR_TX_IDLE = 1'b0,
    WPCR_TX_SEND = 1'b1
  } wpcr_tx_st_t;

  typedef struct packed {
    logic [`WPCR_CNT_W-1:0] last;
    logic [`WPCR_CNT_W-1:0] pend;
    logic [`WPCR_CNT_W-1:0] inc;
    logic [31:0]            acc;
    logic [31:0]            tmr;
    logic                   level;
  } wpcr_och_st_t;

  typedef struct packed {
    logic [1:0]                   pin_s1;
    logic [1:0]                   pin_s2;
    logic [1:0]                   filt;
    logic [1:0][31:0]             filt_cnt;
    wpcr_in_dip_t [1:0]           idip_s1;
    wpcr_in_dip_t [1:0]           idip_s2;
    wpcr_out_dip_t [1:0]          odip_s1;
    wpcr_out_dip_t [1:0]          odip_s2;
    logic [2:0]                   addr_s1;
    logic [2:0]                   addr_s2;
    logic [1:0]                   cfg_stage;
    logic                         cfg_done;
    wpcr_in_dip_t [1:0]           in_cfg;
    wpcr_out_dip_t [1:0]          out_cfg;
    logic [2:0]                   addr;
    logic [1:0][`WPCR_CNT_W-1:0]  cnt;
    logic [1:0][`WPCR_CNT_W-1:0]  edges;
    logic [1:0][`WPCR_CNT_W-1:0]  freq;
    logic [31:0]                  meas_tmr;
    logic [31:0]                  send_tmr;
    logic [31:0]                  flash_tmr;
    logic                         flash;
    logic                         link_ok_q;
    logic [1:0]                   send_req;
    wpcr_tx_st_t                  tx_st;
    wpcr_msg_t                    tx_msg;
    logic                         tx_valid;
    logic [1:0]                   rx_stb;
    logic [`WPCR_CNT_W-1:0]       rx_val;
    logic                         match_seen;
    logic [1:0]                   mismatch;
    logic                         led;
    logic                         tx_en;
    logic                         wr_pend;
    logic [7:0]                   wr_addr;
    logic [31:0]                  hrdata;
    logic                         hreadyout;
    logic                         hresp;
  } wpcr_top_st_t;

endpackage

// ---- rtl/wpcr_out_chan.sv ----
// One regenerating output channel: pulse queue in counter mode, NCO in frequency mode.
// Assumes value strobes from same-clock logic and a mode fixed after power-up.
`timescale 1ns/1ns
`default_nettype none
`include "wpcr_defines.svh"

module wpcr_out_chan
  import wpcr_pkg::*;
#(
  parameter int unsigned FAST_HALF = `WPCR_FAST_HALF_CYC,
  parameter int unsigned SLOW_HALF = `WPCR_SLOW_HALF_CYC,
  parameter int unsigned MEAS_CYC  = `WPCR_MEAS_CYC
) (
  input  wire logic                   clk_sys_i,
  input  wire logic                   reset_n_i,
  input  wire logic                   freq_mode_i,
  input  wire logic                   speed_low_i,
  input  wire logic                   stb_i,
  input  wire logic [`WPCR_CNT_W-1:0] value_i,
  output logic                        pulse_o,
  output logic [`WPCR_CNT_W-1:0]      pend_o
);

  wpcr_och_st_t q;
  wpcr_och_st_t next_q;

  always_comb begin
    logic [`WPCR_CNT_W-1:0] diff;
    logic [32:0]            sum;
    logic [31:0]            half;
    logic                   dec;
    next_q = q;
    diff   = value_i - q.last;
    sum    = {1'b0, q.acc} + {2'b0, q.inc, 1'b0};
    half   = speed_low_i ? SLOW_HALF : FAST_HALF;
    dec    = 1'b0;
    if (freq_mode_i) begin
      // Two toggles per input edge counted over one measuring window
      if (stb_i) begin
        next_q.inc = value_i;
      end
      if (sum >= {1'b0, MEAS_CYC}) begin
        next_q.acc   = 32'(sum - {1'b0, MEAS_CYC});
        next_q.level = ~q.level;
      end else begin
        next_q.acc = sum[31:0];
      end
    end else begin
      if (stb_i) begin
        next_q.last = value_i;
      end
      if (q.tmr != 32'h0) begin
        next_q.tmr = q.tmr - 32'h1;
      end else if (q.level) begin
        next_q.level = 1'b0;
        next_q.tmr   = half - 32'h1;
      end else if (q.pend != '0) begin
        next_q.level = 1'b1;
        next_q.tmr   = half - 32'h1;
        dec          = 1'b1;
      end
      next_q.pend = q.pend + (stb_i ? diff : '0) - {{(`WPCR_CNT_W-1){1'b0}}, dec};
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign pulse_o = q.level;
  assign pend_o  = q.pend;

endmodule // wpcr_out_chan

`default_nettype wire

// ---- rtl/wpcr_top.sv ----
// Two-channel pulse count relay with AHB-Lite register slave.
// Input side counts or measures and sends totals; output side regenerates pulses.
// Assumes the transceiver link logic runs on clk_sys_i; pulse and switch pins are asynchronous.
`timescale 1ns/1ns
`default_nettype none
`include "wpcr_defines.svh"

module wpcr_top
  import wpcr_pkg::*;
#(
  parameter int unsigned FILT_CYC  = `WPCR_FILT_CYC,
  parameter int unsigned FAST_HALF = `WPCR_FAST_HALF_CYC,
  parameter int unsigned SLOW_HALF = `WPCR_SLOW_HALF_CYC,
  parameter int unsigned MEAS_CYC  = `WPCR_MEAS_CYC,
  parameter int unsigned SEND_CYC  = `WPCR_SEND_CYC,
  parameter int unsigned FLASH_CYC = `WPCR_FLASH_CYC
) (
  input  wire logic                clk_sys_i,
  input  wire logic                reset_n_i,
  input  wire logic                hsel_i,
  input  wire logic [31:0]         haddr_i,
  input  wire logic [1:0]          htrans_i,
  input  wire logic                hwrite_i,
  input  wire logic [2:0]          hsize_i,
  input  wire logic [31:0]         hwdata_i,
  input  wire logic                hready_i,
  output logic [31:0]              hrdata_o,
  output logic                     hreadyout_o,
  output logic                     hresp_o,
  input  wire logic [1:0]          pulse_in_i,
  input  wire wpcr_in_dip_t [1:0]  in_dip_i,
  input  wire wpcr_out_dip_t [1:0] out_dip_i,
  input  wire logic [2:0]          addr_code_i,
  input  wire logic                link_up_i,
  input  wire logic                power_ok_i,
  output wpcr_msg_t                tx_msg_o,
  output logic                     tx_valid_o,
  input  wire logic                tx_ready_i,
  input  wire wpcr_msg_t           rx_msg_i,
  input  wire logic                rx_valid_i,
  output logic [1:0]               pulse_out_o,
  output logic                     status_led_o
);

  wpcr_top_st_t                 q;
  wpcr_top_st_t                 next_q;
  logic [1:0][`WPCR_CNT_W-1:0]  pend;

  always_comb begin
    logic         link_ok;
    logic         meas_end;
    logic         send_tick;
    logic         rise;
    logic         ch;
    logic [31:0]  rd;
    wpcr_status_t st;

    // Scratch values start defined on every pass, so no latch is inferred
    rise          = 1'b0;
    ch            = 1'b0;
    rd            = 32'h0;
    next_q        = q;
    link_ok       = link_up_i & power_ok_i;
    meas_end      = (q.meas_tmr == MEAS_CYC - 32'h1);
    send_tick     = (q.send_tmr == SEND_CYC - 32'h1);
    // Receive strobes are one-cycle pulses
    next_q.rx_stb = 2'b00;

    // Synchronisers for asynchronous pins
    // Only the second stage is read anywhere else
    next_q.pin_s1  = pulse_in_i;
    next_q.pin_s2  = q.pin_s1;
    next_q.idip_s1 = in_dip_i;
    next_q.idip_s2 = q.idip_s1;
    next_q.odip_s1 = out_dip_i;
    next_q.odip_s2 = q.odip_s1;
    next_q.addr_s1 = addr_code_i;
    next_q.addr_s2 = q.addr_s1;

    // Switch settings caught once after power-up, then frozen
    // Two settle edges let the synchronisers fill before the capture
    if (!q.cfg_done) begin
      if (q.cfg_stage == `WPCR_CFG_SETTLE) begin
        next_q.cfg_done = 1'b1;
        next_q.in_cfg   = q.idip_s2;
        next_q.out_cfg  = q.odip_s2;
        next_q.addr     = q.addr_s2;
      end else begin
        next_q.cfg_stage = q.cfg_stage + 2'h1;
      end
    end

    // Free-running windows; they start at reset, not at capture,
    // so the first window after power-up may be short of edges
    next_q.meas_tmr = meas_end ? 32'h0 : q.meas_tmr + 32'h1;
    next_q.send_tmr = send_tick ? 32'h0 : q.send_tmr + 32'h1;

    for (int c = 0; c < 2; c++) begin
      // Input filter: low speed demands a stable level, high speed passes through
      // At low speed a level shorter than FILT_CYC cycles never reaches the counter
      if (q.in_cfg[c].speed_high) begin
        next_q.filt[c]     = q.pin_s2[c];
        next_q.filt_cnt[c] = 32'h0;
      end else if (q.pin_s2[c] != q.filt[c]) begin
        if (q.filt_cnt[c] >= FILT_CYC - 32'h1) begin
          next_q.filt[c]     = q.pin_s2[c];
          next_q.filt_cnt[c] = 32'h0;
        end else begin
          next_q.filt_cnt[c] = q.filt_cnt[c] + 32'h1;
        end
      end else begin
        next_q.filt_cnt[c] = 32'h0;
      end

      // Edges before the capture are ignored; the mode is not known yet
      rise = q.cfg_done & next_q.filt[c] & ~q.filt[c];

      // Counting runs regardless of link or supply state
      // The 30-bit total wraps; the far side takes differences modulo 2^30
      if (q.in_cfg[c].freq_mode) begin
        if (meas_end) begin
          next_q.freq[c]     = q.edges[c] + {{(`WPCR_CNT_W-1){1'b0}}, rise};
          next_q.edges[c]    = '0;
          next_q.send_req[c] = 1'b1;
        end else if (rise) begin
          next_q.edges[c] = q.edges[c] + {{(`WPCR_CNT_W-1){1'b0}}, 1'b1};
        end
      end else begin
        if (rise) begin
          next_q.cnt[c] = q.cnt[c] + {{(`WPCR_CNT_W-1){1'b0}}, 1'b1};
        end
        if (send_tick) begin
          next_q.send_req[c] = 1'b1;
        end
      end
    end

    // Link or supply just returned: push both current totals
    // Counts kept during the outage go out as plain totals
    next_q.link_ok_q = link_ok;
    if (link_ok && !q.link_ok_q) begin
      next_q.send_req = 2'b11;
    end

    // First channel wins a tie; the other keeps its request for the next slot
    // Messages wait while tx_en is clear; a request raised in the cycle its channel is taken is cleared with it
    case (q.tx_st)
      WPCR_TX_IDLE: begin
        if (q.cfg_done && q.tx_en && link_ok && q.send_req != 2'b00) begin
          ch                       = ~q.send_req[0];
          next_q.tx_msg.addr       = q.addr;
          next_q.tx_msg.chan       = ch;
          next_q.tx_msg.freq_mode  = q.in_cfg[ch].freq_mode;
          next_q.tx_msg.value      = q.in_cfg[ch].freq_mode ? q.freq[ch] : q.cnt[ch];
          next_q.send_req[ch]      = 1'b0;
          next_q.tx_valid          = 1'b1;
          next_q.tx_st             = WPCR_TX_SEND;
        end
      end
      WPCR_TX_SEND: begin
        if (tx_ready_i) begin
          next_q.tx_valid = 1'b0;
          next_q.tx_st    = WPCR_TX_IDLE;
        end
      end
      default: begin
        next_q.tx_valid = 1'b0;
        next_q.tx_st    = WPCR_TX_IDLE;
      end
    endcase

    // Receive side: only messages carrying our own coding are accepted
    // A mode clash drops the value, so no stray pulses are emitted
    if (!link_up_i) begin
      next_q.match_seen = 1'b0;
    end else if (rx_valid_i && q.cfg_done && rx_msg_i.addr == q.addr) begin
      next_q.match_seen = 1'b1;
      if (rx_msg_i.freq_mode != q.out_cfg[rx_msg_i.chan].freq_mode) begin
        next_q.mismatch[rx_msg_i.chan] = 1'b1;
      end else begin
        next_q.mismatch[rx_msg_i.chan] = 1'b0;
        next_q.rx_stb[rx_msg_i.chan]   = 1'b1;
        next_q.rx_val                  = rx_msg_i.value;
      end
    end

    // The flash timer runs always; a working link simply overrides it
    next_q.flash_tmr = (q.flash_tmr == FLASH_CYC - 32'h1) ? 32'h0 : q.flash_tmr + 32'h1;
    if (q.flash_tmr == FLASH_CYC - 32'h1) begin
      next_q.flash = ~q.flash;
    end
    next_q.led = (link_ok && q.match_seen && q.mismatch == 2'b00) ? 1'b1 : q.flash;

    // AHB-Lite slave: zero wait states, read data registered in the address phase
    // Transfer size is not decoded; only whole-word access is supported
    st            = '0;
    st.addr       = q.addr;
    st.out_cfg    = q.out_cfg;
    st.in_cfg     = q.in_cfg;
    st.mismatch   = q.mismatch;
    st.match_seen = q.match_seen;
    st.link_ok    = q.link_ok_q;
    st.tx_busy    = q.tx_valid;
    st.cfg_done   = q.cfg_done;
    case (haddr_i[7:0])
      `WPCR_REG_CTRL:   rd = {31'h0, q.tx_en};
      `WPCR_REG_STATUS: rd = st;
      `WPCR_REG_CNT0:   rd = {2'h0, q.cnt[0]};
      `WPCR_REG_CNT1:   rd = {2'h0, q.cnt[1]};
      `WPCR_REG_FREQ0:  rd = {2'h0, q.freq[0]};
      `WPCR_REG_FREQ1:  rd = {2'h0, q.freq[1]};
      `WPCR_REG_PEND0:  rd = {2'h0, pend[0]};
      `WPCR_REG_PEND1:  rd = {2'h0, pend[1]};
      default:          rd = 32'h0;
    endcase
    if (haddr_i[31:8] != 24'h0) begin
      rd = 32'h0;
    end
    // Write data follow one cycle after their address phase
    next_q.wr_pend = 1'b0;
    if (hsel_i && hready_i && htrans_i[1]) begin
      // Writes above the map are dropped, as reads there return zero
      next_q.wr_pend = hwrite_i & (haddr_i[31:8] == 24'h0);
      next_q.wr_addr = haddr_i[7:0];
      if (!hwrite_i) begin
        next_q.hrdata = rd;
      end
    end
    if (q.wr_pend && q.wr_addr == `WPCR_REG_CTRL) begin
      next_q.tx_en = hwdata_i[0];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      q           <= '0;
      q.tx_en     <= `WPCR_TX_EN_RST;
      // Never stalls the bus, so ready is high from reset on
      q.hreadyout <= 1'b1;
      q.tx_st     <= WPCR_TX_IDLE;
    end else begin
      q <= next_q;
    end
  end

  // Output channels share one structure, each with its own switches
  // One value bus serves both; the per-channel strobe picks the receiver
  for (genvar c = 0; c < 2; c++) begin : g_out
    wpcr_out_chan #(
      .FAST_HALF (FAST_HALF),
      .SLOW_HALF (SLOW_HALF),
      .MEAS_CYC  (MEAS_CYC)
    ) u_chan (
      .clk_sys_i   (clk_sys_i),
      .reset_n_i   (reset_n_i),
      .freq_mode_i (q.out_cfg[c].freq_mode),
      .speed_low_i (q.out_cfg[c].speed_low),
      .stb_i       (q.rx_stb[c]),
      .value_i     (q.rx_val),
      .pulse_o     (pulse_out_o[c]),
      .pend_o      (pend[c])
    );
  end

  // Each output is a register bit with no logic behind the flops
  assign hrdata_o     = q.hrdata;
  assign hreadyout_o  = q.hreadyout;
  assign hresp_o      = q.hresp;
  assign tx_msg_o     = q.tx_msg;
  assign tx_valid_o   = q.tx_valid;
  assign status_led_o = q.led;

endmodule // wpcr_top

`default_nettype wire

// ---- tb/wpcr_top_asserts.sv ----
// Port-level checks of the pulse count relay.
// Assumes the bench's shortened pulse half periods, handed on by the bind.
`timescale 1ns/1ns
`default_nettype none
module wpcr_top_asserts
  import wpcr_pkg::*;
#(
  parameter int unsigned FAST_HALF = 4,
  parameter int unsigned SLOW_HALF = 10
) (
  input wire logic        clk_sys_i,
  input wire logic        reset_n_i,
  input wire logic        hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic        hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic        hreadyout_o,
  input wire logic        hresp_o,
  input wire logic        link_up_i,
  input wire logic        power_ok_i,
  input wire wpcr_msg_t   tx_msg_o,
  input wire logic        tx_valid_o,
  input wire logic        tx_ready_i,
  input wire logic [1:0]  pulse_out_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  logic [31:0] hi_run;
  // Length of the current high phase of the first output
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i || !pulse_out_o[0])
      hi_run <= 32'h0;
    else
      hi_run <= hi_run + 32'h1;
  end
  chk_resp_okay: assert property (hresp_o == 1'b0)
    else $error("hresp not OKAY");
  chk_ready_high: assert property (hreadyout_o == 1'b1)
    else $error("hreadyout low");
  chk_unmapped_zero: assert property (hsel_i && hready_i && htrans_i[1] && !hwrite_i && haddr_i[31:8] != 24'h0
    |=> hrdata_o == 32'h0) else $error("unmapped read not zero");
  chk_tx_hold: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_msg_o))
    else $error("message dropped or changed before accept");
  chk_tx_gap: assert property (tx_valid_o && tx_ready_i |=> !tx_valid_o)
    else $error("no idle cycle after accept");
  chk_tx_link: assert property ($rose(tx_valid_o) |-> $past(link_up_i && power_ok_i))
    else $error("message sent while link or supply down");
  chk_pulse_width: assert property ($fell(pulse_out_o[0]) |-> hi_run == FAST_HALF || hi_run == SLOW_HALF)
    else $error("output pulse high time wrong");
  chk_reset_quiet: assert property ($rose(reset_n_i) |-> (!tx_valid_o && pulse_out_o == 2'h0)[*3])
    else $error("activity before switches captured");
  cover property (tx_valid_o && tx_ready_i);
  cover property ($fell(pulse_out_o[0]) && hi_run == SLOW_HALF);
  cover property ($rose(pulse_out_o[1]));
endmodule // wpcr_top_asserts

bind wpcr_top wpcr_top_asserts #(.FAST_HALF(FAST_HALF), .SLOW_HALF(SLOW_HALF)) u_chk (
  .clk_sys_i, .reset_n_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hready_i, .hrdata_o, .hreadyout_o,
  .hresp_o, .link_up_i, .power_ok_i, .tx_msg_o, .tx_valid_o, .tx_ready_i, .pulse_out_o
);
`default_nettype wire

// ---- tb/wpcr_peer.sv ----
// Far-side transceiver bus model: accepts sent messages, delivers received ones.
// Assumes the relay's clock; slow_i delays each accept by three cycles.
`timescale 1ns/1ns
`default_nettype none
module wpcr_peer
  import wpcr_pkg::*;
(
  input  wire logic      clk_sys_i,
  input  wire logic      reset_n_i,
  input  wire logic      slow_i,
  input  wire wpcr_msg_t tx_msg_i,
  input  wire logic      tx_valid_i,
  output logic           tx_ready_o,
  output wpcr_msg_t      rx_msg_o,
  output logic           rx_valid_o
);
  wpcr_msg_t [1:0] last_msg;
  int              n_msg [2];
  int              wait_n;
  initial begin
    tx_ready_o = 1'b0;
    rx_valid_o = 1'b0;
    rx_msg_o = '0;
    n_msg = '{0, 0};
    wait_n = 0;
  end
  always @(posedge clk_sys_i) begin
    tx_ready_o <= 1'b0;
    if (!reset_n_i)
      wait_n <= 0;
    else if (tx_valid_i && tx_ready_o) begin
      last_msg[tx_msg_i.chan] <= tx_msg_i;
      n_msg[tx_msg_i.chan] <= n_msg[tx_msg_i.chan] + 1;
    end else if (tx_valid_i) begin
      if (wait_n >= (slow_i ? 3 : 0)) begin
        tx_ready_o <= 1'b1;
        wait_n <= 0;
      end else
        wait_n <= wait_n + 1;
    end
  end
  // Coding and mode come from the caller, so mismatches can be staged
  task automatic send(input wpcr_msg_t m);
    @(posedge clk_sys_i);
    rx_msg_o <= m;
    rx_valid_o <= 1'b1;
    @(posedge clk_sys_i);
    rx_valid_o <= 1'b0;
    rx_msg_o <= ~m;
  endtask
endmodule // wpcr_peer
`default_nettype wire

// ---- tb/wireless_pulse_count_relay_test.sv ----
// Self-checking bench of the relay: register bus, counting, link outage, regeneration.
// Assumes shortened timing parameters; wpcr_peer stands for the far side.
`timescale 1ns/1ns
`default_nettype none
module wireless_pulse_count_relay_test;
  import wpcr_pkg::*;
  logic clk = 1'b0, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, slow = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'h0, pin = 2'h0, pout, pq = 2'h0;
  logic hreadyout, hresp, link_up = 1'b1, power_ok = 1'b1, tx_valid, tx_ready, rx_valid, led, lq = 1'b0;
  wpcr_in_dip_t [1:0] in_dip = {5'b00110, 5'b00010}, cfg_id;
  wpcr_out_dip_t [1:0] out_dip = {2'b10, 2'b00}, cfg_od;
  logic [2:0] code = 3'h2, cfg_c, hsize = 3'h0;
  wpcr_msg_t tx_msg, rx_msg;
  int n_mismatch = 0, n_compared = 0, n_rise [2] = '{0, 0}, n_led = 0, hi_cnt = 0, last_hi = 0, b, n0;
  always #2 clk = ~clk;
  wpcr_top #(.FILT_CYC(8), .FAST_HALF(4), .SLOW_HALF(10), .MEAS_CYC(200), .SEND_CYC(50), .FLASH_CYC(16)) dut (
    .clk_sys_i(clk), .reset_n_i(reset_n), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hreadyout), .hrdata_o(hrdata),
    .hreadyout_o(hreadyout), .hresp_o(hresp), .pulse_in_i(pin), .in_dip_i(in_dip), .out_dip_i(out_dip),
    .addr_code_i(code), .link_up_i(link_up), .power_ok_i(power_ok), .tx_msg_o(tx_msg),
    .tx_valid_o(tx_valid), .tx_ready_i(tx_ready), .rx_msg_i(rx_msg), .rx_valid_i(rx_valid),
    .pulse_out_o(pout), .status_led_o(led));
  wpcr_peer u_peer (.clk_sys_i(clk), .reset_n_i(reset_n), .slow_i(slow), .tx_msg_i(tx_msg),
    .tx_valid_i(tx_valid), .tx_ready_o(tx_ready), .rx_msg_o(rx_msg), .rx_valid_o(rx_valid));
  always @(posedge clk) begin
    pq <= pout;
    lq <= led;
    for (int k = 0; k < 2; k++)
      if (pout[k] === 1'b1 && pq[k] === 1'b0)
        n_rise[k] <= n_rise[k] + 1;
    if (led !== lq)
      n_led <= n_led + 1;
    if (pout[0] === 1'b1)
      hi_cnt <= hi_cnt + 1;
    else if (hi_cnt != 0) begin
      last_hi <= hi_cnt;
      hi_cnt <= 0;
    end
  end
  task automatic test_done();
    if (n_mismatch == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tmo(input int i, input int lim);
    if (i >= lim) begin
      n_mismatch++;
      test_done();
    end
  endtask
  task automatic wrdy();
    int i;
    for (i = 0; i < 16; i++) begin
      @(posedge clk);
      if (hreadyout === 1'b1)
        break;
    end
    tmo(i, 16);
  endtask
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    hsize <= 3'h2;
    wrdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wrdy();
    rd = hrdata;
  endtask
  task automatic wait_msg(input int ch);
    int i;
    n0 = u_peer.n_msg[ch];
    for (i = 0; i < 400; i++) begin
      @(posedge clk);
      if (u_peer.n_msg[ch] != n0)
        break;
    end
    tmo(i, 400);
  endtask
  task automatic pulses(input int ch, input int n, input int w);
    repeat (n) begin
      @(posedge clk);
      pin[ch] <= 1'b1;
      repeat (w) @(posedge clk);
      pin[ch] <= 1'b0;
      repeat (w) @(posedge clk);
    end
  endtask
  task automatic rst();
    @(posedge clk);
    reset_n <= 1'b0;
    cfg_id = in_dip;
    cfg_od = out_dip;
    cfg_c = code;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    ahb(1'b0, 32'h4, 32'h0);
    chk(rd & 32'h007FFFC1, {9'h0, cfg_c, cfg_od, cfg_id, 6'h1});
  endtask
  task automatic dif(input int ch, input logic f, input logic [2:0] a, input logic [29:0] v);
    u_peer.send(wpcr_msg_t'{a, ch[0], f, v});
  endtask
  initial begin
    rst();
    ahb(1'b0, 32'h0, 32'h0);
    chk(rd, 32'h1);
    ahb(1'b1, 32'h0, 32'h0);
    ahb(1'b0, 32'h0, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b1, 32'h0, 32'h1);
    ahb(1'b1, 32'h100, 32'h5A5A5A5A);
    ahb(1'b0, 32'h100, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b0, 32'h20, 32'h0);
    chk(rd, 32'h0);
    // Switch changes while running must stay invisible until the next reset
    in_dip <= {5'b11111, 5'b11001};
    out_dip[0].speed_low <= 1'b1;
    code <= 3'h5;
    slow <= 1'b1;
    pulses(0, 5, 3);
    ahb(1'b0, 32'h4, 32'h0);
    chk(rd & 32'h007FFFC1, {9'h0, cfg_c, cfg_od, cfg_id, 6'h1});
    ahb(1'b0, 32'h8, 32'h0);
    chk(rd, 32'h5);
    wait_msg(0);
    wait_msg(0);
    chk(u_peer.last_msg[0].value, 32'h5);
    chk(u_peer.last_msg[0].addr, 32'h2);
    link_up <= 1'b0;
    pulses(0, 7, 3);
    b = u_peer.n_msg[0];
    repeat (120) @(posedge clk);
    chk(u_peer.n_msg[0] - b, 32'h0);
    ahb(1'b0, 32'h8, 32'h0);
    chk(rd, 32'hC);
    link_up <= 1'b1;
    wait_msg(0);
    chk(u_peer.last_msg[0].value, 32'hC);
    power_ok <= 1'b0;
    pulses(0, 2, 3);
    b = u_peer.n_msg[0];
    repeat (120) @(posedge clk);
    chk(u_peer.n_msg[0] - b, 32'h0);
    power_ok <= 1'b1;
    wait_msg(0);
    chk(u_peer.last_msg[0].value, 32'hE);
    b = n_rise[0];
    dif(0, 1'b0, 3'h2, 30'h3);
    dif(0, 1'b0, 3'h2, 30'hA);
    dif(0, 1'b0, 3'h3, 30'h32);
    dif(0, 1'b0, 3'h2, 30'hC);
    repeat (150) @(posedge clk);
    chk(n_rise[0] - b, 32'hC);
    b = n_led;
    repeat (40) @(posedge clk);
    chk(n_led - b, 32'h0);
    chk(led, 32'h1);
    dif(1, 1'b1, 3'h2, 30'hA);
    repeat (20) @(posedge clk);
    b = n_rise[1];
    repeat (400) @(posedge clk);
    chk(n_rise[1] - b >= 19 && n_rise[1] - b <= 21, 32'h1);
    dif(1, 1'b0, 3'h2, 30'h5);
    repeat (4) @(posedge clk);
    ahb(1'b0, 32'h4, 32'h0);
    chk(rd[5], 32'h1);
    b = n_led;
    repeat (40) @(posedge clk);
    chk(n_led - b > 0, 32'h1);
    rst();
    pulses(0, 3, 3);
    pulses(0, 1, 20);
    repeat (20) @(posedge clk);
    ahb(1'b0, 32'h8, 32'h0);
    chk(rd, 32'h1);
    b = n_rise[0];
    dif(0, 1'b0, 3'h5, 30'h2);
    repeat (60) @(posedge clk);
    chk(n_rise[0] - b, 32'h2);
    chk(last_hi, 32'hA);
    // Align to a window end, then put six edges into the next window
    wait_msg(1);
    pulses(1, 6, 3);
    wait_msg(1);
    chk(u_peer.last_msg[1].value, 32'h6);
    chk(u_peer.last_msg[1].freq_mode, 32'h1);
    ahb(1'b0, 32'h14, 32'h0);
    chk(rd, 32'h6);
    test_done();
  end
endmodule // wireless_pulse_count_relay_test
`default_nettype wire
